// ### src/data_space_decoder.sv
// Data-space decoder with read-only program-memory window, bank routing,
// external readout gate and return stack.
// Assumes one core clock, a program memory that returns data in the same cycle as
// its address, and peripherals that answer their own strobes.
`timescale 1ns/10ps
module data_space_decoder #(
  parameter logic [7:0] FIXED_VALUE = data_space_pkg::FIXED_READ
) (
  // Clock, reset, enable
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                ce,

  // Core data-space request
  input  wire data_space_pkg::core_req_type        coreReq,

  // Core answer for window, write-only and reserved reads
  output logic      [data_space_pkg::DATA_W-1:0]   coreRdData,
  output logic                                     coreRdValid,

  // Resource selection toward RAM, banks and peripherals
  output data_space_pkg::sel_type                  sel,

  // Program memory port
  input  wire logic [data_space_pkg::PROG_W-1:0]   fetchPc,
  output logic      [data_space_pkg::PROG_W-1:0]   progAddr,
  output logic                                     progIsFetch,
  input  wire logic [data_space_pkg::DATA_W-1:0]   progRdData,

  // External readout
  input  wire logic                                readoutProtect,
  input  wire logic                                extReq,
  input  wire logic [data_space_pkg::PROG_W-1:0]   extAddr,
  output logic      [data_space_pkg::DATA_W-1:0]   extData,
  output logic                                     extValid,
  output logic                                     extBlocked,

  // Return stack
  input  wire logic                                stackPush,
  input  wire logic                                stackPop,
  input  wire logic [data_space_pkg::PROG_W-1:0]   stackPushAddr,
  output logic      [data_space_pkg::PROG_W-1:0]   stackRetAddr,
  output logic                                     stackEmpty
);

  // ==========================================================================
  // State
  typedef struct packed {
    data_space_pkg::sel_type                sel;
    logic [data_space_pkg::WIN_BASE_W-1:0]  windowBase;
    logic [data_space_pkg::DATA_W-1:0]      bankSelect;
    // Program port, answers
    logic [data_space_pkg::PROG_W-1:0]      progAddr;
    logic                                   progIsFetch;
    logic                                   winStage;
    logic                                   fixStage;
    logic [data_space_pkg::DATA_W-1:0]      rdData;
    logic                                   rdValid;
    // Readout
    data_space_pkg::ext_state_type          extState;
    logic [data_space_pkg::PROG_W-1:0]      extAddr;
    logic [data_space_pkg::DATA_W-1:0]      extData;
    logic                                   extValid;
    logic                                   extBlocked;
  } dec_state_type;

  localparam dec_state_type STATE_RESET = '{
    sel:         '{target: data_space_pkg::TGT_NONE, index: '0, rd: 1'b0, wr: 1'b0, data: '0},
    windowBase:  '0,
    bankSelect:  '0,
    progAddr:    '0,
    progIsFetch: 1'b0,
    winStage:    1'b0,
    fixStage:    1'b0,
    rdData:      '0,
    rdValid:     1'b0,
    extState:    data_space_pkg::EXT_IDLE,
    extAddr:     '0,
    extData:     '0,
    extValid:    1'b0,
    extBlocked:  1'b0
  };

  dec_state_type state_q;
  dec_state_type state_d;

  // ==========================================================================
  // Decode helpers
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // First match wins
  function automatic data_space_pkg::target_type decode_target(input logic [7:0] a,
                                                               input logic [7:0] bank);
    data_space_pkg::target_type t;
    t = data_space_pkg::TGT_RESERVED;

    if (a <= data_space_pkg::BANK_HI) begin
      // Anything but a single legal bank bit leaves the region unmapped
      if (bank == data_space_pkg::BANK_RAM_VALUE) begin
        t = data_space_pkg::TGT_BANK_RAM;
      end else if (bank == data_space_pkg::BANK_EE_VALUE) begin
        t = data_space_pkg::TGT_BANK_EE;
      end else begin
        t = data_space_pkg::TGT_RESERVED;
      end
    end else if (in_range(a, data_space_pkg::WIN_LO, data_space_pkg::WIN_HI)) begin
      t = data_space_pkg::TGT_WINDOW;
    end else if (in_range(a, data_space_pkg::PTR_X_ADDR, data_space_pkg::PTR_Y_ADDR)) begin
      t = data_space_pkg::TGT_POINTER;
    end else if (in_range(a, data_space_pkg::SHORT_V_ADDR, data_space_pkg::SHORT_W_ADDR)) begin
      t = data_space_pkg::TGT_SHORT;
    end else if (in_range(a, data_space_pkg::RAM_LO, data_space_pkg::RAM_HI)) begin
      t = data_space_pkg::TGT_RAM;
    end else if (in_range(a, data_space_pkg::PORT_DATA_LO, data_space_pkg::PORT_DATA_HI)) begin
      t = data_space_pkg::TGT_PORT_DATA;
    end else if (in_range(a, data_space_pkg::PORT_DIR_LO, data_space_pkg::PORT_DIR_HI)) begin
      t = data_space_pkg::TGT_PORT_DIR;
    end else if (a == data_space_pkg::INT_OPTION) begin
      t = data_space_pkg::TGT_INT_OPT;
    end else if (a == data_space_pkg::WIN_BASE_ADDR) begin
      t = data_space_pkg::TGT_WIN_BASE;
    end else if (in_range(a, data_space_pkg::TIMER_LO, data_space_pkg::TIMER_HI)) begin
      t = data_space_pkg::TGT_TIMER;
    end else if (in_range(a, data_space_pkg::ART_A_LO, data_space_pkg::ART_A_HI) ||
                 in_range(a, data_space_pkg::ART_B_LO, data_space_pkg::ART_B_HI)) begin
      t = data_space_pkg::TGT_ARTIMER;
    end else if (a == data_space_pkg::BANK_SEL_ADDR) begin
      t = data_space_pkg::TGT_BANK_SEL;
    end else if (in_range(a, data_space_pkg::PORT_OPT_LO, data_space_pkg::PORT_OPT_HI) ||
                 in_range(a, data_space_pkg::ADC_LO, data_space_pkg::ADC_HI) ||
                 a == data_space_pkg::WATCHDOG_ADDR || a == data_space_pkg::EE_CTRL_ADDR ||
                 a == data_space_pkg::ACCUM_ADDR) begin
      t = data_space_pkg::TGT_OTHER;
    end

    decode_target = t;
  endfunction

  // Register index within its group, so each peripheral sees 0, 1, 2 ...; TGT_OTHER gets the raw a[5:0]
  function automatic logic [5:0] decode_index(input logic [7:0] a, input data_space_pkg::target_type t);
    logic [7:0] r;
    r = 8'h00;

    case (t)
      data_space_pkg::TGT_BANK_RAM,
      data_space_pkg::TGT_BANK_EE,
      data_space_pkg::TGT_WINDOW:    r = {2'b00, a[5:0]};
      data_space_pkg::TGT_POINTER:   r = a - data_space_pkg::PTR_X_ADDR;
      data_space_pkg::TGT_SHORT:     r = a - data_space_pkg::SHORT_V_ADDR;
      data_space_pkg::TGT_RAM:       r = a - data_space_pkg::RAM_LO;
      data_space_pkg::TGT_PORT_DATA: r = a - data_space_pkg::PORT_DATA_LO;
      data_space_pkg::TGT_PORT_DIR:  r = a - data_space_pkg::PORT_DIR_LO;
      data_space_pkg::TGT_TIMER:     r = a - data_space_pkg::TIMER_LO;
      data_space_pkg::TGT_ARTIMER: begin
        if (a >= data_space_pkg::ART_B_LO) begin
          r = a - data_space_pkg::ART_B_LO + data_space_pkg::ART_B_INDEX;
        end else begin
          r = a - data_space_pkg::ART_A_LO;
        end
      end
      data_space_pkg::TGT_OTHER:     r = a;
      default:                       r = 8'h00;
    endcase

    decode_index = r[5:0];
  endfunction

  // ==========================================================================
  // Next state
  data_space_pkg::target_type tgt;
  logic                       access;
  logic                       winRead;
  logic                       handledHere;

  always_comb begin
    state_d             = state_q;

    // Decode of the standing request
    tgt                 = decode_target(coreReq.addr, state_q.bankSelect);
    access              = coreReq.rd | coreReq.wr;
    winRead             = coreReq.rd && (tgt == data_space_pkg::TGT_WINDOW);
    // Answered here, not by a peripheral
    handledHere         = (tgt == data_space_pkg::TGT_WINDOW) ||
                          (tgt == data_space_pkg::TGT_WIN_BASE) ||
                          (tgt == data_space_pkg::TGT_BANK_SEL) ||
                          (tgt == data_space_pkg::TGT_RESERVED);

    // One-cycle pulses unless set below
    state_d.sel.rd      = 1'b0;
    state_d.sel.wr      = 1'b0;
    state_d.rdValid     = 1'b0;
    state_d.extValid    = 1'b0;
    state_d.winStage    = 1'b0;
    state_d.fixStage    = 1'b0;

    // Answers for requests taken one cycle ago
    if (state_q.winStage) begin
      state_d.rdData  = progRdData;
      state_d.rdValid = 1'b1;
    end else if (state_q.fixStage) begin
      state_d.rdData  = FIXED_VALUE;
      state_d.rdValid = 1'b1;
    end

    // Resource strobes; locally handled targets never strobe outside
    if (access) begin
      state_d.sel.target = tgt;
      state_d.sel.index  = decode_index(coreReq.addr, tgt);
      state_d.sel.data   = coreReq.data;
      state_d.sel.rd     = coreReq.rd && !handledHere;
      state_d.sel.wr     = coreReq.wr && !handledHere;
    end

    // Write-only registers: whole-byte writes only, bit operations dropped
    if (coreReq.wr && !coreReq.bitOp) begin
      if (tgt == data_space_pkg::TGT_WIN_BASE) begin
        state_d.windowBase = coreReq.data[data_space_pkg::WIN_BASE_W-1:0];
      end else if (tgt == data_space_pkg::TGT_BANK_SEL) begin
        state_d.bankSelect = coreReq.data;
      end
    end

    // Reads with nothing behind them get the fixed byte
    if (coreReq.rd && (tgt == data_space_pkg::TGT_WIN_BASE || tgt == data_space_pkg::TGT_BANK_SEL ||
                       tgt == data_space_pkg::TGT_RESERVED)) begin
      state_d.fixStage = 1'b1;
    end

    // Program memory port: window beats external readout beats fetch.
    // A window read steals that fetch slot; progIsFetch tells the core.
    state_d.progAddr    = fetchPc;
    state_d.progIsFetch = 1'b1;
    // Base bits 7:6 were dropped at the write
    if (winRead) begin
      state_d.progAddr    = {state_q.windowBase, coreReq.addr[data_space_pkg::WIN_OFS_W-1:0]};
      state_d.progIsFetch = 1'b0;
      state_d.winStage    = 1'b1;
    end

    // Readout sequencer
    case (state_q.extState)
      data_space_pkg::EXT_IDLE: begin
        // Protected: port never used
        if (extReq) begin
          if (readoutProtect) begin
            state_d.extData    = FIXED_VALUE;
            state_d.extValid   = 1'b1;
            state_d.extBlocked = 1'b1;
          end else begin
            state_d.extAddr    = extAddr;
            state_d.extBlocked = 1'b0;
            state_d.extState   = data_space_pkg::EXT_WAIT;
          end
        end
      end

      data_space_pkg::EXT_WAIT: begin
        if (!winRead) begin
          state_d.progAddr    = state_q.extAddr;
          state_d.progIsFetch = 1'b0;
          state_d.extState    = data_space_pkg::EXT_BUSY;
        end
      end

      data_space_pkg::EXT_BUSY: begin
        state_d.extData  = progRdData;
        state_d.extValid = 1'b1;
        state_d.extState = data_space_pkg::EXT_IDLE;
      end

      default: begin
        state_d.extState = data_space_pkg::EXT_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // Base and bank registers keep their value through reset
  // so software writes them before first use
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q            <= STATE_RESET;
      state_q.windowBase <= state_q.windowBase;
      state_q.bankSelect <= state_q.bankSelect;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Return stack
  return_stack #(
    .DEPTH (data_space_pkg::STACK_DEPTH),
    .WIDTH (data_space_pkg::PROG_W)
  ) u_return_stack (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .push     (stackPush),
    .pop      (stackPop),
    .pushAddr (stackPushAddr),
    .retAddr  (stackRetAddr),
    .empty    (stackEmpty)
  );

  // ==========================================================================
  // Outputs
  // All straight from state
  assign coreRdData  = state_q.rdData;
  assign coreRdValid = state_q.rdValid;

  assign sel         = state_q.sel;

  assign progAddr    = state_q.progAddr;
  assign progIsFetch = state_q.progIsFetch;

  assign extData     = state_q.extData;
  assign extValid    = state_q.extValid;
  assign extBlocked  = state_q.extBlocked;

endmodule

// ### src/data_space_pkg.sv
// Shared constants and carrier types for the data-space decoder.
// Assumes an 8-bit data space and a 12-bit program memory on one core clock.
package data_space_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W      = 8;
  localparam int PROG_W      = 12;
  localparam int WIN_OFS_W   = 6;
  localparam int WIN_BASE_W  = 6;
  localparam int STACK_DEPTH = 6;

  // ==========================================================================
  // Data-space map
  localparam logic [7:0] BANK_HI        = 8'h3f;
  localparam logic [7:0] WIN_LO         = 8'h40;
  localparam logic [7:0] WIN_HI         = 8'h7f;
  localparam logic [7:0] PTR_X_ADDR     = 8'h80;
  localparam logic [7:0] PTR_Y_ADDR     = 8'h81;
  localparam logic [7:0] SHORT_V_ADDR   = 8'h82;
  localparam logic [7:0] SHORT_W_ADDR   = 8'h83;
  localparam logic [7:0] RAM_LO         = 8'h84;
  localparam logic [7:0] RAM_HI         = 8'hbf;
  localparam logic [7:0] PORT_DATA_LO   = 8'hc0;
  localparam logic [7:0] PORT_DATA_HI   = 8'hc2;
  localparam logic [7:0] PORT_DIR_LO    = 8'hc4;
  localparam logic [7:0] PORT_DIR_HI    = 8'hc6;
  localparam logic [7:0] INT_OPTION     = 8'hc8;
  localparam logic [7:0] WIN_BASE_ADDR  = 8'hc9;
  localparam logic [7:0] PORT_OPT_LO    = 8'hcc;
  localparam logic [7:0] PORT_OPT_HI    = 8'hce;
  localparam logic [7:0] ADC_LO         = 8'hd0;
  localparam logic [7:0] ADC_HI         = 8'hd1;
  localparam logic [7:0] TIMER_LO       = 8'hd2;
  localparam logic [7:0] TIMER_HI       = 8'hd4;
  localparam logic [7:0] ART_A_LO       = 8'hd5;
  localparam logic [7:0] ART_A_HI       = 8'hd7;
  localparam logic [7:0] WATCHDOG_ADDR  = 8'hd8;
  localparam logic [7:0] ART_B_LO       = 8'hd9;
  localparam logic [7:0] ART_B_HI       = 8'hdb;
  localparam logic [7:0] BANK_SEL_ADDR  = 8'he8;
  localparam logic [7:0] EE_CTRL_ADDR   = 8'hea;
  localparam logic [7:0] ACCUM_ADDR     = 8'hff;

  // ==========================================================================
  // Bank select encodings, second-timer index offset and fixed answers
  localparam logic [7:0] BANK_RAM_VALUE = 8'h10;
  localparam logic [7:0] BANK_EE_VALUE  = 8'h01;
  localparam logic [7:0] ART_B_INDEX    = 8'h03;
  localparam logic [7:0] FIXED_READ     = 8'hff;

  typedef enum logic [4:0] {
    TGT_NONE      = 5'h00,
    TGT_BANK_RAM  = 5'h01,
    TGT_BANK_EE   = 5'h02,
    TGT_WINDOW    = 5'h03,
    TGT_POINTER   = 5'h04,
    TGT_SHORT     = 5'h05,
    TGT_RAM       = 5'h06,
    TGT_PORT_DATA = 5'h07,
    TGT_PORT_DIR  = 5'h08,
    TGT_INT_OPT   = 5'h09,
    TGT_WIN_BASE  = 5'h0a,
    TGT_TIMER     = 5'h0b,
    TGT_ARTIMER   = 5'h0c,
    TGT_BANK_SEL  = 5'h0d,
    TGT_OTHER     = 5'h0e,
    TGT_RESERVED  = 5'h0f
  } target_type;

  typedef enum logic [1:0] {
    EXT_IDLE = 2'b00,
    EXT_WAIT = 2'b01,
    EXT_BUSY = 2'b10
  } ext_state_type;

  typedef struct packed {
    logic             rd;
    logic             wr;
    logic             bitOp;
    logic [7:0]       addr;
    logic [DATA_W-1:0] data;
  } core_req_type;

  typedef struct packed {
    target_type        target;
    logic [5:0]        index;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] data;
  } sel_type;

endpackage

// ### src/return_stack.sv
// Six-level return-address stack of program-counter width.
// Assumes the core never pushes and pops in the same cycle; push wins if it does.
`timescale 1ns/10ps
module return_stack #(
  parameter int DEPTH = data_space_pkg::STACK_DEPTH,
  parameter int WIDTH = data_space_pkg::PROG_W
) (
  // Clock and control
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Core side
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] pushAddr,
  output logic      [WIDTH-1:0] retAddr,
  output logic                  empty
);

  localparam int IDX_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] entry;
    logic [IDX_W-1:0]            wrIdx;
    logic [IDX_W-1:0]            count;
    logic [WIDTH-1:0]            retAddr;
    logic                        empty;
  } stack_state_type;

  stack_state_type state_q;
  stack_state_type state_d;

  function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i);
    next_idx = (i == IDX_W'(DEPTH - 1)) ? '0 : i + 1'b1;
  endfunction

  function automatic logic [IDX_W-1:0] prev_idx(input logic [IDX_W-1:0] i);
    prev_idx = (i == '0) ? IDX_W'(DEPTH - 1) : i - 1'b1;
  endfunction

  // ==========================================================================
  // Next state
  // Past six levels the oldest entry is overwritten, as a ring
  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.entry[state_q.wrIdx] = pushAddr;
      state_d.wrIdx                = next_idx(state_q.wrIdx);
      if (state_q.count != IDX_W'(DEPTH)) begin
        state_d.count = state_q.count + 1'b1;
      end
    end else if (pop && state_q.count != '0) begin
      state_d.wrIdx   = prev_idx(state_q.wrIdx);
      state_d.count   = state_q.count - 1'b1;
      state_d.retAddr = state_q.entry[prev_idx(state_q.wrIdx)];
    end
    state_d.empty = (state_d.count == '0);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q.wrIdx   <= '0;
      state_q.count   <= '0;
      state_q.retAddr <= '0;
      state_q.entry   <= '0;
      state_q.empty   <= 1'b1;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign retAddr = state_q.retAddr;
  assign empty   = state_q.empty;

endmodule

// ### verif/data_space_asserts.sv
// Port checker for the data-space decoder.
// Assumes one core clock, synchronous reset and one-cycle request pulses.
`timescale 1ns/10ps
module data_space_asserts (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         rst,
  input wire logic                         ce,
  // Core side
  input wire data_space_pkg::core_req_type coreReq,
  input wire logic [7:0]                   coreRdData,
  input wire logic                         coreRdValid,
  input wire data_space_pkg::sel_type      sel,
  // Program memory and readout
  input wire logic [11:0]                  progAddr,
  input wire logic [7:0]                   progRdData,
  input wire logic                         readoutProtect,
  input wire logic                         extReq,
  input wire logic [7:0]                   extData,
  input wire logic                         extValid,
  input wire logic                         extBlocked,
  // Return stack
  input wire logic                         stackPush,
  input wire logic                         stackPop,
  input wire logic [11:0]                  stackPushAddr,
  input wire logic [11:0]                  stackRetAddr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ====
  // Request shapes
  sequence winRd; ce && coreReq.rd && coreReq.addr[7:6] == 2'b01; endsequence
  sequence baseWr; ce && coreReq.wr && !coreReq.bitOp && coreReq.addr == 8'hc9; endsequence
  sequence deadAcc; ce && (coreReq.rd || coreReq.wr) && coreReq.addr inside {8'hc3, 8'hc7, 8'hc9, 8'he9}; endsequence
  sequence fixedRd; ce && coreReq.rd && coreReq.addr inside {8'hc3, 8'hc7, 8'hc9, 8'he9}; endsequence
  sequence pushPop; ce && stackPush ##1 ce && stackPop && !stackPush; endsequence
  // ====
  // Properties
  win_offset_a: assert property (winRd |=> progAddr[5:0] == $past(coreReq.addr[5:0]))
    else $error("window offset wrong");
  win_base_a: assert property (baseWr ##1 winRd |=> progAddr[11:6] == $past(coreReq.data[5:0], 2))
    else $error("window base wrong");
  win_data_a: assert property (winRd ##1 ce |=> coreRdValid && coreRdData == $past(progRdData))
    else $error("window data wrong");
  dead_strobe_a: assert property (deadAcc |=> !sel.rd && !sel.wr)
    else $error("strobe on dead address");
  fixed_read_a: assert property (fixedRd ##1 ce |=> coreRdValid && coreRdData == 8'hff)
    else $error("fixed read wrong");
  ram_index_a: assert property (ce && coreReq.wr && coreReq.addr inside {[8'h84:8'hbf]} |=>
    sel.wr && sel.target == data_space_pkg::TGT_RAM && sel.data == $past(coreReq.data) &&
    sel.index == $past(coreReq.addr[5:0]) - 6'h04)
    else $error("ram decode wrong");
  ptr_decode_a: assert property (ce && coreReq.rd && coreReq.addr[7:2] == 6'h20 |=> sel.rd &&
    sel.target == ($past(coreReq.addr[1]) ? data_space_pkg::TGT_SHORT : data_space_pkg::TGT_POINTER))
    else $error("pointer decode wrong");
  ext_block_a: assert property (ce && extReq && !$past(extReq) && readoutProtect |=>
    extValid && extBlocked && extData == 8'hff)
    else $error("readout not blocked");
  stack_ret_a: assert property (pushPop |=> stackRetAddr == $past(stackPushAddr, 2))
    else $error("stack return wrong");
endmodule
bind data_space_decoder data_space_asserts chk (.mclk(mclk), .rst(rst), .ce(ce), .coreReq(coreReq),
  .coreRdData(coreRdData), .coreRdValid(coreRdValid), .sel(sel), .progAddr(progAddr), .progRdData(progRdData),
  .readoutProtect(readoutProtect), .extReq(extReq), .extData(extData), .extValid(extValid),
  .extBlocked(extBlocked), .stackPush(stackPush), .stackPop(stackPop), .stackPushAddr(stackPushAddr),
  .stackRetAddr(stackRetAddr));

// ### verif/prog_mem_model.sv
// Program memory model on the decoder's program port.
// Assumes the decoder registers progAddr; data follows it within the cycle.
`timescale 1ns/10ps
module prog_mem_model (
  // Program port
  input  wire logic [11:0] progAddr,
  output logic      [7:0]  progRdData
);
  // Both address halves mixed in, so base and offset slips both show
  assign progRdData = progAddr[7:0] ^ {progAddr[11:8], progAddr[11:8]};
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the data-space decoder.
// Assumes the checker binds itself; the memory model answers the program port.
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, coreRdValid, progIsFetch, readoutProtect = 1'b0, extReq = 1'b0;
  logic extValid, extBlocked, stackPush = 1'b0, stackPop = 1'b0, stackEmpty;
  logic [7:0] coreRdData, progRdData, extData, base, bank, v;
  logic [11:0] fetchPc = 12'h123, progAddr, extAddr = 12'h000, stackPushAddr = 12'h000, stackRetAddr;
  logic [11:0] sv [7];
  data_space_pkg::core_req_type coreReq = '0;
  data_space_pkg::sel_type sel;
  logic [7:0] rdQ [$];
  logic [11:0] selQ [$];
  logic [8:0] extQ [$];
  integer seed = 81349, n_fail = 0, check_count = 0;
  always #2.5 mclk = ~mclk;
  data_space_decoder dut (.mclk(mclk), .rst(rst), .ce(ce), .coreReq(coreReq), .coreRdData(coreRdData),
    .coreRdValid(coreRdValid), .sel(sel), .fetchPc(fetchPc), .progAddr(progAddr), .progIsFetch(progIsFetch),
    .progRdData(progRdData), .readoutProtect(readoutProtect), .extReq(extReq), .extAddr(extAddr),
    .extData(extData), .extValid(extValid), .extBlocked(extBlocked), .stackPush(stackPush), .stackPop(stackPop),
    .stackPushAddr(stackPushAddr), .stackRetAddr(stackRetAddr), .stackEmpty(stackEmpty));
  prog_mem_model mem (.progAddr(progAddr), .progRdData(progRdData));
  // ====
  // Helpers
  function automatic logic [7:0] rom(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction
  // Result code {indexMatters, target, index}; zero means a fixed 0xff read
  function automatic logic [11:0] cls(input logic [7:0] a);
    logic [5:0] o;
    o = a[5:0];
    case (a) inside
      [8'h80:8'h81]: return {1'b1, data_space_pkg::TGT_POINTER, o};
      [8'h82:8'h83]: return {1'b1, data_space_pkg::TGT_SHORT, o - 6'h02};
      [8'h84:8'hbf]: return {1'b1, data_space_pkg::TGT_RAM, o - 6'h04};
      [8'hc0:8'hc2]: return {1'b1, data_space_pkg::TGT_PORT_DATA, o};
      [8'hc4:8'hc6]: return {1'b1, data_space_pkg::TGT_PORT_DIR, o - 6'h04};
      8'hc8: return {1'b0, data_space_pkg::TGT_INT_OPT, 6'h00};
      [8'hd2:8'hd4]: return {1'b1, data_space_pkg::TGT_TIMER, o - 6'h12};
      [8'hd5:8'hd7]: return {1'b1, data_space_pkg::TGT_ARTIMER, o - 6'h15};
      [8'hd9:8'hdb]: return {1'b1, data_space_pkg::TGT_ARTIMER, o - 6'h16};
      8'hcc, 8'hcd, 8'hce, 8'hd0, 8'hd1, 8'hd8, 8'hea, 8'hff: return {1'b1, data_space_pkg::TGT_OTHER, o};
      default: return 12'h000;
    endcase
  endfunction
  task automatic cmpVal(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpSel(input logic [11:0] e);
    cmpVal({1'b0, sel.target, e[11] ? sel.index : 6'h00}, {1'b0, e[10:0]});
  endtask
  task automatic acc(input logic r, input logic w, input logic b, input logic [7:0] a, input logic [7:0] d);
    coreReq = '{rd: r, wr: w, bitOp: b, addr: a, data: d};
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    logic [11:0] c;
    c = cls(a);
    if (a < 8'h40) c = (bank == 8'h10) ? {1'b0, data_space_pkg::TGT_BANK_RAM, 6'h00} :
      (bank == 8'h01) ? {1'b0, data_space_pkg::TGT_BANK_EE, 6'h00} : 12'h000;
    if (a[7:6] == 2'b01) rdQ.push_back(rom({base[5:0], a[5:0]}));
    else if (c == 12'h000) rdQ.push_back(8'hff);
    else selQ.push_back(c);
    acc(1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ====
  // Result watcher
  always @(negedge mclk) begin
    if (coreRdValid === 1'b1) cmpVal({4'h0, coreRdData}, {4'h0, rdQ.size() > 0 ? rdQ.pop_front() : 8'hxx});
    if (sel.rd === 1'b1 || sel.wr === 1'b1) cmpSel(selQ.size() > 0 ? selQ.pop_front() : 12'hxxx);
    if (extValid === 1'b1) cmpVal({3'h0, extBlocked, extData}, {3'h0, extQ.size() > 0 ? extQ.pop_front() : 9'hxxx});
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  // ====
  // Stimulus
  initial begin
    repeat (12) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      base = $random(seed);
      acc(1'b0, 1'b1, 1'b0, 8'hc9, base);
      rd(8'h40);
      rd(8'h7f);
      rd(8'h40 | 8'($random(seed) & 63));
    end
    acc(1'b0, 1'b1, 1'b1, 8'hc9, ~base);
    rd(8'h55);
    for (int a = 128; a < 256; a++) rd(8'(a));
    for (int i = 0; i < 4; i++) begin
      v = 8'h84 + 8'($unsigned($random(seed)) % 60);
      selQ.push_back(cls(v));
      acc(1'b0, 1'b1, 1'b0, v, 8'($random(seed)));
      acc(1'b0, 1'b1, 1'b0, 8'hc3 + {i[1:0], 2'b00}, 8'h5a);
    end
    foreach (sv[i]) if (i < 3) begin
      bank = (i == 0) ? 8'h10 : (i == 1) ? 8'h01 : 8'h02;
      acc(1'b0, 1'b1, 1'b0, 8'he8, bank);
      rd(8'h00);
      rd(8'h3f);
    end
    acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    fetchPc = 12'($random(seed));
    repeat (2) @(posedge mclk);
    #1 cmpVal(progAddr, fetchPc);
    cmpVal({11'h0, progIsFetch}, 12'h001);
    rst = 1'b1;
    @(posedge mclk);
    #1 rst = 1'b0;
    rd(8'h40);
    acc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
    readoutProtect = 1'b1;
    extQ.push_back(9'h1ff);
    extReq = 1'b1;
    @(posedge mclk);
    #1 extReq = 1'b0;
    repeat (4) @(posedge mclk);
    #1 readoutProtect = 1'b0;
    extAddr = 12'($random(seed));
    extQ.push_back({1'b0, rom(extAddr)});
    extReq = 1'b1;
    @(posedge mclk);
    #1 extReq = 1'b0;
    stackPush = 1'b1;
    for (int k = 0; k < 7; k++) begin
      sv[k] = 12'($random(seed));
      stackPushAddr = sv[k];
      @(posedge mclk);
      #1;
    end
    stackPush = 1'b0;
    stackPop = 1'b1;
    for (int k = 0; k < 6; k++) begin
      @(posedge mclk);
      #1 cmpVal(stackRetAddr, sv[6 - k]);
    end
    stackPop = 1'b0;
    cmpVal({11'h0, stackEmpty}, 12'h001);
    for (int k = 0; k < 40 && (rdQ.size() + selQ.size() + extQ.size()) > 0; k++) @(posedge mclk);
    if (rdQ.size() + selQ.size() + extQ.size() > 0) n_fail++;
    report_and_stop();
  end
endmodule
